// ---- chsts_pkg.sv ----
package chsts_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
    localparam int unsigned FAULT_DB_MS     = 2;
    localparam int unsigned FAULT_DB_CYCLES = FAULT_DB_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned RDY_HIGH_US     = 24;
    localparam int unsigned RDY_HIGH_CYCLES =
        RDY_HIGH_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int unsigned DIN_DB_UNIT_CYC = 1000;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 16;
    localparam logic [7:0]  ADDR_LIVE  = 8'h2f;
    localparam logic [7:0]  ADDR_ALERT = 8'h2e;
    localparam logic [15:0] LIVE_RESET  = 16'h0000;
    localparam logic [15:0] ALERT_RESET = 16'h0000;
    localparam int BIT_FAULT_A  = 0;
    localparam int BIT_REG_1V8  = 9;
    localparam int SRC_LSB      = 10;
    localparam int SRC_MSB      = 12;
    localparam int BIT_BUSY     = 13;
    localparam int BIT_DATA_RDY = 14;

    // ------------------------------------------------------------------
    // Channel function codes and fault modes
    // ------------------------------------------------------------------
    localparam int         FUNC_W        = 4;
    localparam logic [3:0] FUNC_VOUT     = 4'h1;
    localparam logic [3:0] FUNC_IOUT     = 4'h2;
    localparam logic [3:0] FUNC_IIN_EXT  = 4'h4;
    localparam logic [3:0] FUNC_IIN_LOOP = 4'h5;
    localparam int         DB_FIELD_W    = 5;
    localparam int         CNT_W         = 32;

    typedef enum logic [2:0] {
        FM_NONE,
        FM_VOUT_SHORT,
        FM_IOUT_OPEN,
        FM_IIN_LOOP_GND,
        FM_IIN_EXT_OVER
    } chsts_mode_t;

    // Map the channel function onto the fault it watches
    function automatic chsts_mode_t decode_mode(input logic [3:0] func);
        chsts_mode_t m;
        m = FM_NONE;
        if (func == FUNC_VOUT) m = FM_VOUT_SHORT;
        if (func == FUNC_IOUT) m = FM_IOUT_OPEN;
        if (func == FUNC_IIN_LOOP) m = FM_IIN_LOOP_GND;
        if (func == FUNC_IIN_EXT) m = FM_IIN_EXT_OVER;
        return m;
    endfunction

endpackage

// ---- chsts_db_if.sv ----
`timescale 1ns/1ps
interface chsts_db_if;
    logic                     cond;      // Selected raw fault condition
    logic                     restart;   // Function changed, start over
    logic [chsts_pkg::CNT_W-1:0] limit;  // Cycles the condition must hold
    logic                     qualified; // Debounced condition

    modport ctrl (output cond, output restart, output limit, input qualified);
    modport deb  (input cond, input restart, input limit, output qualified);
endinterface

// ---- chsts_debounce.sv ----
`timescale 1ns/1ps
module chsts_debounce (
    input  wire logic   core_clk, // System clock
    input  wire logic   nrst,     // Async reset, active low
    chsts_db_if.deb     db        // Condition and limit in, result out
);

    logic [chsts_pkg::CNT_W-1:0] cnt_reg;
    logic                        qual_reg;

    assign db.qualified = qual_reg;

    // ------------------------------------------------------------------
    // Hold counter
    // ------------------------------------------------------------------
    // Any gap in the condition restarts the wait, so glitches never count
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg  <= '0;
            qual_reg <= 1'b0;
        end else if (db.restart || !db.cond) begin
            cnt_reg  <= '0;
            qual_reg <= 1'b0;
        end else if (cnt_reg >= db.limit - 32'h1) begin
            qual_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

endmodule

// ---- chsts_top.sv ----
`timescale 1ns/1ps
module chsts_top #(
    parameter logic [31:0] FAULT_DB_CYC = chsts_pkg::FAULT_DB_CYCLES,
    parameter logic [31:0] DIN_DB_UNIT  = chsts_pkg::DIN_DB_UNIT_CYC
) (
    input  wire logic        core_clk,          // 100 MHz clock
    input  wire logic        nrst,              // Async reset, active low
    input  wire logic [3:0]  chan_a_function_select, // Channel A function
    input  wire logic        comp_enable,       // Input comparator on
    input  wire logic        comp_trip_half,    // Trip at half analog supply
    input  wire logic        comparator_output_invert, // Inversion bit
    input  wire logic [4:0]  din_debounce_time, // Debounce field
    input  wire logic        short_circuit_pin, // Raw short detector
    input  wire logic        open_circuit_pin,  // Raw open detector
    input  wire logic        comp_out_pin,      // Raw comparator output
    input  wire logic        regulator_1v8_fault, // Raw regulator error
    input  wire logic        adc_conv_done,     // Pulse, conversion finished
    input  wire logic        adc_busy,          // Converter busy level
    input  wire logic [2:0]  current_conversion_source, // Item converting
    input  wire logic        adc_continuous,    // Continuous mode select
    input  wire logic        reg_wr,            // Register write strobe
    input  wire logic        reg_rd,            // Register read strobe
    input  wire logic [7:0]  reg_addr,          // Register address
    input  wire logic [15:0] reg_wdata,         // Write data
    output logic      [15:0] reg_rdata,         // Read data, next cycle
    output logic             adc_rdy_n,         // Data ready pin, low active
    output logic             chan_a_fault_flag  // Latched channel A fault
);

    // Every check below runs on core_clk and sleeps during reset
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;

    // Analog detectors are asynchronous to core_clk
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {regulator_1v8_fault, comp_out_pin,
                          open_circuit_pin, short_circuit_pin};
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Fault selection and debounce
    // ------------------------------------------------------------------
    chsts_pkg::chsts_mode_t mode;
    chsts_pkg::chsts_mode_t mode_reg;
    chsts_db_if             db ();
    logic [31:0]            din_limit;

    assign mode      = chsts_pkg::decode_mode(chan_a_function_select);
    assign din_limit = 32'(({27'h0, din_debounce_time} + 32'h1) * DIN_DB_UNIT);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= chsts_pkg::FM_NONE;
        end else begin
            mode_reg <= mode;
        end
    end

    // Function picks condition
    // A function change restarts the wait so old history never leaks over
    always_comb begin
        db.restart = (mode != mode_reg);
        db.cond    = 1'b0;
        db.limit   = FAULT_DB_CYC;
        unique case (mode)
            chsts_pkg::FM_VOUT_SHORT: db.cond = sync2_reg[0];
            chsts_pkg::FM_IOUT_OPEN: db.cond = sync2_reg[1];
            chsts_pkg::FM_IIN_LOOP_GND: begin
                db.cond  = comp_enable && comp_trip_half &&
                           comparator_output_invert && sync2_reg[2];
                db.limit = din_limit;
            end
            chsts_pkg::FM_IIN_EXT_OVER: begin
                db.cond  = comp_enable && comp_trip_half && sync2_reg[2];
                db.limit = din_limit;
            end
            chsts_pkg::FM_NONE: db.cond = 1'b0;
        endcase
    end

    chsts_debounce u_debounce (
        .core_clk (core_clk),
        .nrst     (nrst),
        .db       (db)
    );

    // ------------------------------------------------------------------
    // Sticky flags
    // ------------------------------------------------------------------
    logic alert_clr;
    logic rdy_clr;
    logic data_rdy_reg;
    logic data_rdy_next;

    assign alert_clr = reg_wr && (reg_addr == chsts_pkg::ADDR_ALERT) &&
                       reg_wdata[chsts_pkg::BIT_FAULT_A];
    assign rdy_clr   = reg_wr && (reg_addr == chsts_pkg::ADDR_LIVE) &&
                       reg_wdata[chsts_pkg::BIT_DATA_RDY];
    // Write one clears
    // A completion in the clearing cycle wins, no conversion is lost
    assign data_rdy_next = adc_conv_done || (data_rdy_reg && !rdy_clr);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            data_rdy_reg <= 1'b0;
        end else begin
            data_rdy_reg <= data_rdy_next;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chan_a_fault_flag <= 1'b0;
        end else begin
            chan_a_fault_flag <= db.qualified ||
                                 (chan_a_fault_flag && !alert_clr);
        end
    end

    // ------------------------------------------------------------------
    // Ready pin
    // ------------------------------------------------------------------
    logic [11:0] rdy_cnt_reg;

    // Continuous 24 us pulse
    // Continuous mode ignores the flag; a new completion re-arms the pulse
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            adc_rdy_n   <= 1'b1;
            rdy_cnt_reg <= 12'h000;
        end else if (!adc_continuous) begin
            adc_rdy_n   <= !data_rdy_next;
            rdy_cnt_reg <= 12'h000;
        end else if (adc_conv_done) begin
            adc_rdy_n   <= 1'b0;
            rdy_cnt_reg <= 12'(chsts_pkg::RDY_HIGH_CYCLES - 1);
        end else if (rdy_cnt_reg != 12'h000) begin
            rdy_cnt_reg <= rdy_cnt_reg - 12'h001;
        end else begin
            adc_rdy_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Live status and read path
    // ------------------------------------------------------------------
    logic [4:0]  live_misc_reg;
    logic [15:0] live_word;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            live_misc_reg <= 5'h00;
        end else begin
            live_misc_reg <= {adc_busy, current_conversion_source,
                              sync2_reg[3]};
        end
    end

    always_comb begin
        live_word = chsts_pkg::LIVE_RESET;
        live_word[chsts_pkg::BIT_DATA_RDY] = data_rdy_reg;
        live_word[chsts_pkg::BIT_BUSY]     = live_misc_reg[4];
        live_word[chsts_pkg::SRC_MSB:chsts_pkg::SRC_LSB] = live_misc_reg[3:1];
        live_word[chsts_pkg::BIT_REG_1V8]  = live_misc_reg[0];
        live_word[chsts_pkg::BIT_FAULT_A]  = db.qualified;
    end

    // Unmapped addresses read zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                chsts_pkg::ADDR_LIVE:  reg_rdata <= live_word;
                chsts_pkg::ADDR_ALERT: reg_rdata <= {15'h0000,
                                                     chan_a_fault_flag};
                default:               reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [31:0] run_reg;
    logic [11:0] low_reg;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            run_reg <= 32'h0;
            low_reg <= 12'h000;
        end else begin
            run_reg <= (db.restart || !db.cond) ? 32'h0 :
                       (run_reg == 32'hffffffff) ? run_reg : run_reg + 32'h1;
            low_reg <= (adc_rdy_n || adc_conv_done) ? 12'h000 :
                       low_reg + 12'h001;
        end
    end

    a_mode_change_clr: assert property ((mode != mode_reg) |=>
        !db.qualified) else $error("fault survived a function change");
    a_vout_debounce: assert property ($rose(db.qualified) &&
        mode_reg == chsts_pkg::FM_VOUT_SHORT |-> run_reg >= FAULT_DB_CYC)
        else $error("short fault set before 2 ms");
    a_iout_debounce: assert property ($rose(db.qualified) &&
        mode_reg == chsts_pkg::FM_IOUT_OPEN |-> run_reg >= FAULT_DB_CYC)
        else $error("open fault set before 2 ms");
    a_loop_qualify: assert property (
        mode == chsts_pkg::FM_IIN_LOOP_GND &&
        !(comp_enable && comp_trip_half) |=> !db.qualified)
        else $error("loop fault without comparator setup");
    a_ext_qualify: assert property (
        mode == chsts_pkg::FM_IIN_EXT_OVER &&
        !(comp_enable && comp_trip_half) |=> !db.qualified)
        else $error("overcurrent fault without comparator setup");
    a_din_debounce: assert property ($rose(db.qualified) &&
        (mode_reg == chsts_pkg::FM_IIN_EXT_OVER ||
         mode_reg == chsts_pkg::FM_IIN_LOOP_GND) |-> run_reg >= din_limit)
        else $error("input fault set before debounce");
    a_rdy_set: assert property (adc_conv_done |=> data_rdy_reg)
        else $error("ready flag missed a completion");
    a_rdy_hold: assert property (data_rdy_reg && !rdy_clr |=>
        data_rdy_reg) else $error("ready flag dropped without clear");
    a_single_pin: assert property (!adc_continuous ##1 1'b1 |->
        adc_rdy_n == !data_rdy_reg)
        else $error("ready pin differs from flag");
    // Pulse length bound, the pin is low for no more than the count
    a_cont_pulse: assert property (adc_continuous |->
        low_reg <= 12'(chsts_pkg::RDY_HIGH_CYCLES))
        else $error("ready pin low past 24 us");
    a_src_read: assert property (
        reg_rd && reg_addr == chsts_pkg::ADDR_LIVE |=>
        reg_rdata[12:10] == $past(current_conversion_source, 2))
        else $error("source code readback wrong");
    a_fault_hold: assert property (chan_a_fault_flag && !alert_clr |=>
        chan_a_fault_flag)
        else $error("latched fault dropped without clear");

    c_fault_set: cover property ($rose(chan_a_fault_flag));
    c_rdy_clear: cover property (data_rdy_reg && rdy_clr);
    c_cont_release: cover property (adc_continuous && $rose(adc_rdy_n));

endmodule

// ---- chsts_host.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Host model: owns the register strobes and channel configuration
// ----------------------------------------------------------------------
module chsts_host (
    input  wire logic        core_clk,                 // System clock
    output logic      [3:0]  chan_a_function_select,   // Channel A function
    output logic             comp_enable,              // Comparator on
    output logic             comp_trip_half,           // Half-supply trip
    output logic             comparator_output_invert, // Inversion bit
    output logic      [4:0]  din_debounce_time,        // Debounce field
    output logic             reg_wr,                   // Write strobe
    output logic             reg_rd,                   // Read strobe
    output logic      [7:0]  reg_addr,                 // Address
    output logic      [15:0] reg_wdata,                // Write data
    input  wire logic [15:0] reg_rdata                 // Read data
);
    // Idle bus and a neutral configuration from time zero
    initial begin
        {chan_a_function_select, comp_enable, comp_trip_half} = '0;
        {comparator_output_invert, din_debounce_time} = '0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end

    // Host sets inversion
    // Field 7 gives an input debounce of 8 units, which still runs short
    task automatic setup(input logic [3:0] f, input logic [2:0] k);
        @(posedge core_clk);
        chan_a_function_select <= f;
        {comp_enable, comp_trip_half, comparator_output_invert} <= k;
        din_debounce_time <= 5'h07;
    endtask

    // Released lines show the inverse so stale values are never trusted
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'h0, ~a, ~d};
    endtask

    // Data is taken just after the edge that accepts the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'h1, a};
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'h0, ~a};
        #1 d = reg_rdata;
    endtask
endmodule

// ---- channel_fault_live_status_bench.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin \
    total_checks++; \
    if ((a) !== (b)) begin \
        error_cnt++; \
        $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
    end \
end
module channel_fault_live_status_bench;
    logic        core_clk, nrst;               // Clock and reset
    logic [3:0]  chan_a_function_select;       // From host
    logic        comp_enable, comp_trip_half;  // From host
    logic        comparator_output_invert;     // From host
    logic [4:0]  din_debounce_time;            // From host
    logic        short_circuit_pin;            // Raw short
    logic        open_circuit_pin;             // Raw open
    logic        comp_out_pin;                 // Raw comparator
    logic        regulator_1v8_fault;          // Raw regulator error
    logic        adc_conv_done, adc_busy;      // Converter status
    logic [2:0]  current_conversion_source;    // Item converting
    logic        adc_continuous;               // Mode select
    logic        reg_wr, reg_rd;               // Strobes
    logic [7:0]  reg_addr;                     // Address
    logic [15:0] reg_wdata, reg_rdata;         // Data
    logic        adc_rdy_n, chan_a_fault_flag; // Outputs
    int          error_cnt, total_checks, cyc; // Bookkeeping

    // Short debounce counts keep the run brief
    chsts_top #(.FAULT_DB_CYC(32'h10), .DIN_DB_UNIT(32'h2)) dut (
        .core_clk, .nrst, .chan_a_function_select, .comp_enable,
        .comp_trip_half, .comparator_output_invert, .din_debounce_time,
        .short_circuit_pin, .open_circuit_pin, .comp_out_pin,
        .regulator_1v8_fault, .adc_conv_done, .adc_busy,
        .current_conversion_source, .adc_continuous, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .adc_rdy_n, .chan_a_fault_flag);

    chsts_host host (
        .core_clk, .chan_a_function_select, .comp_enable, .comp_trip_half,
        .comparator_output_invert, .din_debounce_time, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata);

    // Clock and a hang guard well above the expected run length
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic pulse();
        @(posedge core_clk);
        adc_conv_done <= 1'h1;
        @(posedge core_clk);
        adc_conv_done <= 1'h0;
        #1;
    endtask

    // One fault case: debounce not yet over, then settled, then removed
    task automatic fc(input logic [3:0] f, input logic [2:0] p,
                      input logic [2:0] k, input logic e);
        host.setup(f, k);
        @(posedge core_clk);
        {short_circuit_pin, open_circuit_pin, comp_out_pin} <= p;
        tick(10);
        `CHK(chan_a_fault_flag, 1'h0)
        tick(50);
        `CHK(chan_a_fault_flag, e)
        rd_chk(8'h2f, {15'h0000, e});
        @(posedge core_clk);
        {short_circuit_pin, open_circuit_pin, comp_out_pin} <= 3'h0;
        tick(6);
        rd_chk(8'h2f, 16'h0000);
        `CHK(chan_a_fault_flag, e)
        host.wr(8'h2e, 16'h0001);
        tick(0);
        `CHK(chan_a_fault_flag, 1'h0)
    endtask

    initial begin
        int n;
        logic [15:0] exp;
        {nrst, short_circuit_pin, open_circuit_pin, comp_out_pin} = '0;
        {regulator_1v8_fault, adc_conv_done, adc_busy} = '0;
        {current_conversion_source, adc_continuous} = '0;
        {error_cnt, total_checks, cyc} = '0;
        repeat (20) @(posedge core_clk);
        nrst <= 1'h1;
        tick(1);
        `CHK(adc_rdy_n, 1'h1)
        `CHK(chan_a_fault_flag, 1'h0)
        rd_chk(8'h2f, 16'h0000);
        rd_chk(8'h2e, 16'h0000);
        rd_chk(8'h00, 16'h0000);
        $display("test reset done");

        // Every source code, busy and regulator toggling, writes ignored
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            adc_busy <= i[0];
            current_conversion_source <= i[2:0];
            regulator_1v8_fault <= i[1];
            tick(5);
            host.wr(8'h2f, 16'hbfff);
            exp = {2'h0, i[0], i[2:0], i[1], 9'h000};
            rd_chk(8'h2f, exp);
        end
        @(posedge core_clk);
        {adc_busy, current_conversion_source, regulator_1v8_fault} <= '0;
        tick(5);
        $display("test live mirror done");

        // Single mode: pin held until the flag is cleared
        pulse();
        `CHK(adc_rdy_n, 1'h0)
        tick(50);
        `CHK(adc_rdy_n, 1'h0)
        rd_chk(8'h2f, 16'h4000);
        host.wr(8'h2f, 16'h4000);
        tick(0);
        `CHK(adc_rdy_n, 1'h1)
        rd_chk(8'h2f, 16'h0000);
        $display("test single ready done");

        // Continuous mode: pin low for 24 us, flag stays set
        @(posedge core_clk);
        adc_continuous <= 1'h1;
        pulse();
        n = 0;
        while (adc_rdy_n === 1'h0 && n < 3000) begin
            n++;
            tick(1);
        end
        `CHK(n, chsts_pkg::RDY_HIGH_CYCLES)
        rd_chk(8'h2f, 16'h4000);
        host.wr(8'h2f, 16'h4000);
        rd_chk(8'h2f, 16'h0000);
        $display("test continuous ready done");

        // Function table: fault meaning follows the selected function
        fc(chsts_pkg::FUNC_VOUT, 3'h4, 3'h0, 1'h1);
        fc(chsts_pkg::FUNC_VOUT, 3'h3, 3'h6, 1'h0);
        fc(chsts_pkg::FUNC_IOUT, 3'h2, 3'h0, 1'h1);
        fc(chsts_pkg::FUNC_IIN_EXT, 3'h1, 3'h6, 1'h1);
        fc(chsts_pkg::FUNC_IIN_EXT, 3'h1, 3'h2, 1'h0);
        fc(chsts_pkg::FUNC_IIN_LOOP, 3'h1, 3'h7, 1'h1);
        fc(chsts_pkg::FUNC_IIN_LOOP, 3'h1, 3'h6, 1'h0);
        fc(chsts_pkg::FUNC_IIN_LOOP, 3'h1, 3'h5, 1'h0);
        fc(4'h0, 3'h7, 3'h7, 1'h0);
        $display("test channel fault done");
        end_of_test();
    end
endmodule
